//--- logic/buzzer_pkg.sv
/*
 Constants, field layout, timing and helper functions of the buzzer
 tone generator. Assumes a 32.768 kHz low-speed oscillator whose both
 edges give the half-tick of the divider chain.
*/
// Function
// - Enable drives tone; disabled pin stays low except during a one-shot burst
// - Tone runs free of enable; glitches allowed
// - Tones are integer divisions of oscillator
// - Three-bit select picks one of eight tones
// - Level selects high-time count per frequency group
// - Duty is high time over period
// - Envelope overrides software level field
// - Envelope enable bit switches envelope on
// - Envelope starts at maximum, steps toward minimum
// - Envelope holds minimum level once reached
// - Restart returns envelope to maximum
// - Rate bit selects 62.5 or 125 ms steps
// - First step may be up to 4 ms off
// - Width bit selects 31.25 or 125 ms
// - Trigger starts burst on 256 Hz tick
// - Burst ends on 256 Hz tick after duration
// - Trigger bit reads busy during burst
// - Stop bit ends burst on tick
// - Retrigger restarts full duration on tick
// - Bursts use software level, never envelope
// - Continuous enable blocks one-shot triggers

package buzzer_pkg;

    // Register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_SHOT = 4'h4;
    localparam logic [3:0] OFS_FREQ = 4'h8;
    localparam logic [3:0] OFS_LEVEL = 4'hc;

    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_ENV_BIT = 1;
    localparam int CTRL_RST_BIT = 2;
    localparam int CTRL_RATE_BIT = 3;

    // One-shot register fields
    localparam int SHOT_WIDTH_BIT = 0;
    localparam int SHOT_TRIG_BIT = 1;
    localparam int SHOT_STOP_BIT = 2;

    // Values after reset and envelope level limits
    localparam logic RST_BIT = 1'b0;
    localparam logic [2:0] RST_FIELD = 3'h0;
    localparam logic [2:0] LEVEL_MAX = 3'h0;
    localparam logic [2:0] LEVEL_MIN = 3'h7;

    // Timebase, in half-ticks of the oscillator
    localparam int OSC_HZ = 32768;
    localparam int HALF_TICK_HZ = 2 * OSC_HZ;
    localparam int TICK_HZ = 256;
    localparam logic [7:0] TICK_DIV_LAST =
        8'(HALF_TICK_HZ / TICK_HZ - 1);

    // Times in ns and their counts of 256 Hz ticks
    localparam int TICK_NS = 1000000000 / TICK_HZ;
    localparam int ENV_FAST_NS = 62500000;
    localparam int ENV_SLOW_NS = 125000000;
    localparam int SHOT_LONG_NS = 125000000;
    localparam int SHOT_SHORT_NS = 31250000;
    localparam logic [5:0] ENV_FAST_TICKS = 6'(ENV_FAST_NS / TICK_NS);
    localparam logic [5:0] ENV_SLOW_TICKS = 6'(ENV_SLOW_NS / TICK_NS);
    localparam logic [5:0] SHOT_LONG_TICKS = 6'(SHOT_LONG_NS / TICK_NS);
    localparam logic [5:0] SHOT_SHORT_TICKS =
        6'(SHOT_SHORT_NS / TICK_NS);

    // Tone period and high time, in half-ticks
    localparam int TONE_BASE_PERIOD = 16;
    localparam int TONE_PERIOD_STEP = 4;
    localparam int HIGH_NARROW = 8;
    localparam int HIGH_WIDE = 12;

    typedef enum logic [1:0] {
        OS_IDLE = 2'b00,
        OS_RUN = 2'b01
    } shot_state_t;

    function automatic logic [4:0] periodOf(input logic [2:0] f);
        return 5'(TONE_BASE_PERIOD + TONE_PERIOD_STEP * int'(f[1:0]));
    endfunction

    function automatic logic [4:0] highOf(input logic [2:0] f,
                                          input logic [2:0] lvl);
        return 5'((f[1] ? HIGH_WIDE : HIGH_NARROW) - int'(lvl));
    endfunction

endpackage

//--- logic/buzzer_tone_generator.sv
/*
 Buzzer tone generator: divider chain from the low-speed oscillator,
 tone with selectable duty, digital envelope, one-shot burst and an
 Avalon-MM slave for the control bits. Assumes the oscillator pin is
 asynchronous to ref_clk and much slower than it.
*/
`timescale 1ns/1ns
`default_nettype none

module buzzer_tone_generator (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic lowSpeedOscillator,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic toneOutPin
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    logic oscMeta_r, oscMeta_nxt;
    logic oscSync_r, oscSync_nxt;
    logic oscPrev_r, oscPrev_nxt;
    logic pre_r, pre_nxt;
    logic [7:0] tickDiv_r, tickDiv_nxt;
    logic halfTick;
    logic tick256;
    logic toneStep;

    logic [4:0] pos_r, pos_nxt;
    logic toneOut_r, toneOut_nxt;
    logic wave;
    logic [2:0] effLevel;

    logic enable_r, enable_nxt;
    logic envOn_r, envOn_nxt;
    logic rate_r, rate_nxt;
    logic width_r, width_nxt;
    logic [2:0] freq_r, freq_nxt;
    logic [2:0] level_r, level_nxt;
    logic waitReq_r, waitReq_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic busDone;
    logic wrLow;
    logic restartPulse;
    logic trigPulse;
    logic stopPulse;

    logic [2:0] envLevel_r, envLevel_nxt;
    logic [5:0] envCnt_r, envCnt_nxt;
    logic [5:0] envInterval;
    logic envRun;

    buzzer_pkg::shot_state_t osState_r, osState_nxt;
    logic startPend_r, startPend_nxt;
    logic stopPend_r, stopPend_nxt;
    logic [5:0] osCnt_r, osCnt_nxt;
    logic shotBusy;
    logic armReq;

    ////////////////////////////////////////////////////////////////////
    // Timebase from the oscillator

    always_comb begin
        oscMeta_nxt = lowSpeedOscillator;
        oscSync_nxt = oscMeta_r;
        oscPrev_nxt = oscSync_r;
        halfTick = oscSync_r ^ oscPrev_r;
        tick256 = halfTick && (tickDiv_r == buzzer_pkg::TICK_DIV_LAST);
        pre_nxt = pre_r;
        tickDiv_nxt = tickDiv_r;
        if (halfTick) begin
            pre_nxt = ~pre_r;
            tickDiv_nxt = 8'(tickDiv_r + 8'h01);
        end
        // Lower octave advances on every other half-tick
        toneStep = halfTick && (!freq_r[2] || pre_r);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            oscMeta_r <= 1'b0;
            oscSync_r <= 1'b0;
            oscPrev_r <= 1'b0;
            pre_r <= 1'b0;
            tickDiv_r <= 8'h00;
        end else begin
            oscMeta_r <= oscMeta_nxt;
            oscSync_r <= oscSync_nxt;
            oscPrev_r <= oscPrev_nxt;
            pre_r <= pre_nxt;
            tickDiv_r <= tickDiv_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Tone waveform and pin

    always_comb begin
        effLevel = envRun ? envLevel_r : level_r;
        pos_nxt = pos_r;
        if (toneStep) begin
            if (pos_r == 5'(buzzer_pkg::periodOf(freq_r) - 5'h01)) begin
                pos_nxt = 5'h00;
            end else begin
                pos_nxt = 5'(pos_r + 5'h01);
            end
        end
        wave = pos_r < buzzer_pkg::highOf(freq_r, effLevel);
        // Tone keeps running while gated off
        toneOut_nxt = (enable_r || osState_r == buzzer_pkg::OS_RUN)
                      && wave;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pos_r <= 5'h00;
            toneOut_r <= 1'b0;
        end else begin
            pos_r <= pos_nxt;
            toneOut_r <= toneOut_nxt;
        end
    end

    assign toneOutPin = toneOut_r;

    ////////////////////////////////////////////////////////////////////
    // Bus slave and control bits

    always_comb begin
        busDone = (read || write) && !waitReq_r;
        wrLow = busDone && write && byteenable[0];
        restartPulse = wrLow && address == buzzer_pkg::OFS_CTRL
                       && writedata[buzzer_pkg::CTRL_RST_BIT];
        trigPulse = wrLow && address == buzzer_pkg::OFS_SHOT
                    && writedata[buzzer_pkg::SHOT_TRIG_BIT];
        stopPulse = wrLow && address == buzzer_pkg::OFS_SHOT
                    && writedata[buzzer_pkg::SHOT_STOP_BIT];
        waitReq_nxt = !((read || write) && waitReq_r);
        enable_nxt = enable_r;
        envOn_nxt = envOn_r;
        rate_nxt = rate_r;
        width_nxt = width_r;
        freq_nxt = freq_r;
        level_nxt = level_r;
        if (wrLow) begin
            case (address)
                buzzer_pkg::OFS_CTRL: begin
                    enable_nxt = writedata[buzzer_pkg::CTRL_EN_BIT];
                    envOn_nxt = writedata[buzzer_pkg::CTRL_ENV_BIT];
                    rate_nxt = writedata[buzzer_pkg::CTRL_RATE_BIT];
                end
                buzzer_pkg::OFS_SHOT: begin
                    width_nxt = writedata[buzzer_pkg::SHOT_WIDTH_BIT];
                end
                buzzer_pkg::OFS_FREQ: begin
                    freq_nxt = writedata[2:0];
                end
                buzzer_pkg::OFS_LEVEL: begin
                    level_nxt = writedata[2:0];
                end
                default: begin
                end
            endcase
        end
        rdata_nxt = rdata_r;
        if (read && waitReq_r) begin
            rdata_nxt = 32'h00000000;
            case (address)
                buzzer_pkg::OFS_CTRL: begin
                    rdata_nxt[buzzer_pkg::CTRL_EN_BIT] = enable_r;
                    rdata_nxt[buzzer_pkg::CTRL_ENV_BIT] = envOn_r;
                    rdata_nxt[buzzer_pkg::CTRL_RATE_BIT] = rate_r;
                end
                buzzer_pkg::OFS_SHOT: begin
                    rdata_nxt[buzzer_pkg::SHOT_WIDTH_BIT] = width_r;
                    rdata_nxt[buzzer_pkg::SHOT_TRIG_BIT] = shotBusy;
                end
                buzzer_pkg::OFS_FREQ: begin
                    rdata_nxt[2:0] = freq_r;
                end
                buzzer_pkg::OFS_LEVEL: begin
                    rdata_nxt[2:0] = level_r;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable_r <= buzzer_pkg::RST_BIT;
            envOn_r <= buzzer_pkg::RST_BIT;
            rate_r <= buzzer_pkg::RST_BIT;
            width_r <= buzzer_pkg::RST_BIT;
            freq_r <= buzzer_pkg::RST_FIELD;
            level_r <= buzzer_pkg::RST_FIELD;
            waitReq_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end else begin
            enable_r <= enable_nxt;
            envOn_r <= envOn_nxt;
            rate_r <= rate_nxt;
            width_r <= width_nxt;
            freq_r <= freq_nxt;
            level_r <= level_nxt;
            waitReq_r <= waitReq_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign readdata = rdata_r;
    assign waitrequest = waitReq_r;

    ////////////////////////////////////////////////////////////////////
    // Envelope

    always_comb begin
        envRun = enable_r && envOn_r;
        envInterval = rate_r ? buzzer_pkg::ENV_SLOW_TICKS
                             : buzzer_pkg::ENV_FAST_TICKS;
        envLevel_nxt = envLevel_r;
        envCnt_nxt = envCnt_r;
        // Tick phase is free, so first step is up to one tick short
        if (!envRun || restartPulse) begin
            envLevel_nxt = buzzer_pkg::LEVEL_MAX;
            envCnt_nxt = 6'h00;
        end else if (tick256) begin
            if (envCnt_r == 6'(envInterval - 6'h01)) begin
                envCnt_nxt = 6'h00;
                if (envLevel_r != buzzer_pkg::LEVEL_MIN) begin
                    envLevel_nxt = 3'(envLevel_r + 3'h1);
                end
            end else begin
                envCnt_nxt = 6'(envCnt_r + 6'h01);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            envLevel_r <= buzzer_pkg::LEVEL_MAX;
            envCnt_r <= 6'h00;
        end else begin
            envLevel_r <= envLevel_nxt;
            envCnt_r <= envCnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One-shot burst

    always_comb begin
        armReq = trigPulse && !enable_r;
        shotBusy = startPend_r || osState_r == buzzer_pkg::OS_RUN;
        // Requests wait for the tick; a new request wins over the clear
        startPend_nxt = armReq || (startPend_r && !tick256);
        stopPend_nxt = stopPulse || (stopPend_r && !tick256);
        osState_nxt = osState_r;
        osCnt_nxt = osCnt_r;
        if (tick256) begin
            if (startPend_r) begin
                osState_nxt = buzzer_pkg::OS_RUN;
                osCnt_nxt = width_r ? buzzer_pkg::SHOT_LONG_TICKS
                                    : buzzer_pkg::SHOT_SHORT_TICKS;
            end else if (stopPend_r) begin
                osState_nxt = buzzer_pkg::OS_IDLE;
            end else begin
                case (osState_r)
                    buzzer_pkg::OS_RUN: begin
                        if (osCnt_r == 6'h01) begin
                            osState_nxt = buzzer_pkg::OS_IDLE;
                        end else begin
                            osCnt_nxt = 6'(osCnt_r - 6'h01);
                        end
                    end
                    default: begin
                        osState_nxt = buzzer_pkg::OS_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            osState_r <= buzzer_pkg::OS_IDLE;
            startPend_r <= 1'b0;
            stopPend_r <= 1'b0;
            osCnt_r <= 6'h00;
        end else begin
            osState_r <= osState_nxt;
            startPend_r <= startPend_nxt;
            stopPend_r <= stopPend_nxt;
            osCnt_r <= osCnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence shotArm;
        trigPulse && !enable_r && !tick256;
    endsequence
    sequence shotTick;
        tick256 && startPend_r;
    endsequence
    sequence shotRead;
        read && waitrequest && address == buzzer_pkg::OFS_SHOT;
    endsequence

    AST_PIN_LOW_OFF: assert property (
        (!enable_r && osState_r == buzzer_pkg::OS_IDLE) |=> !toneOutPin)
        else $error("pin not low while output off");
    AST_PIN_WAVE: assert property (
        enable_r |=> toneOutPin == $past(wave))
        else $error("pin does not follow tone");
    AST_PERIOD_WRAP: assert property (
        (toneStep && pos_r == 5'(buzzer_pkg::periodOf(freq_r) - 5'h01))
        |=> pos_r == 5'h00)
        else $error("tone period wrong");
    AST_ENV_START: assert property (
        $rose(envRun) |-> envLevel_r == buzzer_pkg::LEVEL_MAX)
        else $error("envelope not at maximum on start");
    AST_ENV_HOLD: assert property (
        (envRun && envLevel_r == buzzer_pkg::LEVEL_MIN && !restartPulse)
        ##1 envRun |-> envLevel_r == buzzer_pkg::LEVEL_MIN)
        else $error("envelope left minimum");
    AST_ENV_RESTART: assert property (
        (envRun && restartPulse) |=> envLevel_r == buzzer_pkg::LEVEL_MAX
        && envCnt_r == 6'h00)
        else $error("envelope restart failed");
    AST_ENV_STEP: assert property (
        (envRun && tick256 && !restartPulse
         && envCnt_r == 6'(envInterval - 6'h01)
         && envLevel_r != buzzer_pkg::LEVEL_MIN)
        |=> envLevel_r == 3'($past(envLevel_r) + 3'h1))
        else $error("envelope step wrong");
    AST_SHOT_ALIGN: assert property (
        $changed(osState_r) |-> $past(tick256))
        else $error("one-shot edge off the tick");
    AST_SHOT_PEND: assert property (
        shotArm |=> startPend_r)
        else $error("one-shot request not held");
    AST_SHOT_ARM: assert property (
        shotTick |=> osState_r == buzzer_pkg::OS_RUN
        && osCnt_r == ($past(width_r) ? buzzer_pkg::SHOT_LONG_TICKS
                                      : buzzer_pkg::SHOT_SHORT_TICKS))
        else $error("one-shot did not start on tick");
    AST_SHOT_BLOCKED: assert property (
        (trigPulse && enable_r && !startPend_r) |=> !startPend_r)
        else $error("trigger taken while enabled");
    AST_BUSY_READ: assert property (
        shotRead |=> readdata[buzzer_pkg::SHOT_TRIG_BIT] == $past(shotBusy))
        else $error("busy bit reads wrong");

endmodule

`default_nettype wire

//--- tb/buzzer_tone_generator_test.sv
/*
 Self-checking bench of the buzzer tone generator: register access,
 tone sweep, envelope steps and one-shot bursts. Assumes an oscillator
 pin toggling every 4 ref_clk cycles, so one half-tick is 4 cycles and
 one 256 Hz tick is 1024 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHECK(nm, exp, got) begin checksDone++; \
    if ((got) !== (exp)) begin numErrors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module buzzer_tone_generator_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic lowSpeedOscillator = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    logic toneOutPin;
    logic [15:0] highCycles;
    logic [15:0] periodCycles;
    logic [15:0] riseCount;
    logic [31:0] lfsr = 32'hc10f;
    logic [31:0] rdata = 32'h0;
    logic [1:0] oscCnt = 2'h0;
    int numErrors = 0;
    int checksDone = 0;
    int cycleNow = 0;
    int t0 = 0;

    buzzer_tone_generator u_buzzer_tone_generator (
        .ref_clk(ref_clk), .rst(rst),
        .lowSpeedOscillator(lowSpeedOscillator),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .toneOutPin(toneOutPin)
    );

    piezo_model u_piezo_model (
        .ref_clk(ref_clk), .toneOutPin(toneOutPin),
        .highCycles(highCycles), .periodCycles(periodCycles),
        .riseCount(riseCount)
    );

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycleNow <= cycleNow + 1;
        oscCnt <= oscCnt + 2'h1;
        if (oscCnt == 2'h3) begin
            lowSpeedOscillator <= ~lowSpeedOscillator;
        end
    end

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] expPeriod(input logic [2:0] f);
        return 16'((16 + 4 * f[1:0]) * (f[2] ? 8 : 4));
    endfunction

    function automatic logic [15:0] expHigh(input logic [2:0] f,
                                            input logic [2:0] l);
        return 16'(((f[1] ? 12 : 8) - l) * (f[2] ? 8 : 4));
    endfunction

    function automatic logic inRange(input int v, input int lo,
                                     input int hi);
        return v >= lo && v <= hi;
    endfunction

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic timeoutIf(input logic hit);
        if (hit) begin
            numErrors++;
            $display("[FAIL] wait expected done seen timeout");
            conclude();
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [3:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge ref_clk);
        address <= a;
        writedata <= {lfsr[31:4], d};
        byteenable <= be;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
        timeoutIf(waitrequest !== 1'b0);
    endtask

    task automatic waitRises(input int k);
        int n;
        logic [15:0] r;
        n = 0;
        r = riseCount + 16'(k);
        while (riseCount !== r && n < 1300) begin
            @(posedge ref_clk);
            n++;
        end
        timeoutIf(n >= 1300);
    endtask

    task automatic tone(input logic [2:0] f, input logic [2:0] l);
        waitRises(3);
        `CHECK("period", expPeriod(f), periodCycles)
        `CHECK("highTime", expHigh(f, l), highCycles)
    endtask

    task automatic envStep(input int ticks);
        int n;
        int lo;
        n = 0;
        lo = (ticks - 1) * 1024;
        while (highCycles === expHigh(3'h0, 3'h0) && n < 40000) begin
            @(posedge ref_clk);
            n++;
        end
        timeoutIf(n >= 40000);
        n = cycleNow - t0;
        `CHECK("envHigh", expHigh(3'h0, 3'h1), highCycles)
        `CHECK("envTime", 1'b1, inRange(n, lo, lo + 1324))
    endtask

    task automatic idle(input int lo, input int hi);
        int n;
        n = 0;
        do begin
            bus(1'b0, 4'h4, 4'h0, 4'hf);
            n++;
        end while (rdata[1] !== 1'b0 && n < 15000);
        timeoutIf(n >= 15000);
        `CHECK("shotTime", 1'b1, inRange(cycleNow - t0, lo, hi))
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] adr[4];
        logic [3:0] wv[4];
        logic [3:0] ev[4];
        logic [2:0] f;
        logic [2:0] l;
        logic [15:0] r;
        adr = '{4'h0, 4'h4, 4'h8, 4'hc};
        wv = '{4'h8, 4'h1, 4'hf, 4'hd};
        ev = '{4'h8, 4'h1, 4'h7, 4'h5};
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, adr[i], 4'h0, 4'hf);
            `CHECK("resetValue", 32'h0, rdata)
            bus(1'b1, adr[i], wv[i], 4'hf);
            bus(1'b0, adr[i], 4'h0, 4'hf);
            `CHECK("readBack", {28'h0, ev[i]}, rdata)
        end
        bus(1'b1, 4'h8, 4'h2, 4'h0);
        bus(1'b0, 4'h8, 4'h0, 4'hf);
        `CHECK("laneOff", 32'h7, rdata)
        bus(1'b0, 4'h6, 4'h0, 4'hf);
        `CHECK("unmapped", 32'h0, rdata)
        // Continuous tone, envelope off, every code
        bus(1'b1, 4'h0, 4'h1, 4'hf);
        bus(1'b1, 4'h4, 4'h2, 4'hf);
        bus(1'b0, 4'h4, 4'h0, 4'hf);
        `CHECK("shotIgnored", 32'h0, rdata)
        for (int i = 0; i < 16; i++) begin
            lfsr = lfsrNext(lfsr);
            f = 3'(i % 8);
            l = (i < 8) ? 3'(7 - i) : lfsr[2:0];
            bus(1'b1, 4'h8, {1'b0, f}, {lfsr[6:4], 1'b1});
            bus(1'b1, 4'hc, {1'b0, l}, {lfsr[9:7], 1'b1});
            tone(f, l);
        end
        // Envelope: software level 7 must not matter
        bus(1'b1, 4'h0, 4'h0, 4'hf);
        bus(1'b1, 4'h8, 4'h0, 4'hf);
        bus(1'b1, 4'hc, 4'h7, 4'hf);
        bus(1'b1, 4'h0, 4'h3, 4'hf);
        t0 = cycleNow;
        tone(3'h0, 3'h0);
        envStep(16);
        bus(1'b1, 4'h0, 4'hf, 4'hf);
        t0 = cycleNow;
        tone(3'h0, 3'h0);
        envStep(32);
        // One-shot with envelope bit left on
        bus(1'b1, 4'h0, 4'h2, 4'hf);
        bus(1'b1, 4'hc, 4'h2, 4'hf);
        r = riseCount;
        repeat (300) @(posedge ref_clk);
        `CHECK("quietPin", r, riseCount)
        `CHECK("lowPin", 1'b0, toneOutPin)
        bus(1'b1, 4'h4, 4'h2, 4'hf);
        t0 = cycleNow;
        bus(1'b0, 4'h4, 4'h0, 4'hf);
        `CHECK("busy", 32'h2, rdata)
        waitRises(1);
        `CHECK("shotStart", 1'b1, inRange(cycleNow - t0, 0, 1124))
        tone(3'h0, 3'h2);
        idle(8 * 1024 - 8, 9 * 1024 + 60);
        r = riseCount;
        repeat (300) @(posedge ref_clk);
        `CHECK("shotOff", r, riseCount)
        // Long burst, then early stop
        bus(1'b1, 4'h4, 4'h3, 4'hf);
        repeat (10000) @(posedge ref_clk);
        bus(1'b0, 4'h4, 4'h0, 4'hf);
        `CHECK("longBusy", 32'h3, rdata)
        bus(1'b1, 4'h4, 4'h4, 4'hf);
        t0 = cycleNow;
        idle(0, 1100);
        // Retrigger mid-burst
        bus(1'b1, 4'h4, 4'h2, 4'hf);
        repeat (2000) @(posedge ref_clk);
        bus(1'b1, 4'h4, 4'h2, 4'hf);
        t0 = cycleNow;
        idle(8 * 1024 - 8, 9 * 1024 + 60);
        conclude();
    end
endmodule
`default_nettype wire

//--- tb/piezo_model.sv
/*
 Piezo buzzer model: times the high level and the period of the tone
 pin and counts its rising edges. Assumes a pin registered on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module piezo_model (
    input wire logic ref_clk,
    input wire logic toneOutPin,
    output logic [15:0] highCycles,
    output logic [15:0] periodCycles,
    output logic [15:0] riseCount
);
    logic [15:0] sinceRise = 16'h0;
    logic lastPin = 1'b0;

    initial begin
        highCycles = 16'h0;
        periodCycles = 16'h0;
        riseCount = 16'h0;
    end

    always @(posedge ref_clk) begin
        lastPin <= toneOutPin;
        sinceRise <= sinceRise + 16'h1;
        if (toneOutPin && !lastPin) begin
            periodCycles <= sinceRise;
            riseCount <= riseCount + 16'h1;
            sinceRise <= 16'h1;
        end
        if (!toneOutPin && lastPin) begin
            highCycles <= sinceRise;
        end
    end
endmodule
`default_nettype wire
